// ---- design/bsreg_top.sv ----
// test access port with identification, bypass and boundary scan registers
`timescale 1ns/1ns
`include "bsreg_consts.svh"

module bsreg_top #(
  parameter int BSR_LEN = `BSREG_BSR_LEN,
  parameter logic [3:0] ID_VERSION = 4'h1,      // arbitrary value
  parameter logic [15:0] ID_PART = 16'hA5C3,    // arbitrary value
  parameter logic [10:0] ID_MFR = 11'h2B4       // arbitrary value
) (
  // system clock and reset
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  // scan pins to and from the test controller
  input wire bsreg_pkg::bsreg_pins_s SCAN_PINS_I,
  output logic SCAN_SERIAL_OUT_O,
  output logic SCAN_SERIAL_OUT_OE_O,
  // boundary cells
  input wire logic [BSR_LEN-1:0] BSR_PIN_I,
  output logic [BSR_LEN-1:0] BSR_PAR_O,
  // pin control and current instruction
  output bsreg_pkg::bsreg_pinctl_s PIN_CTL_O,
  output logic [`BSREG_IR_W-1:0] IR_O
);

  // every assertion below runs on the system clock and rests during reset
  default clocking cb_sys @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);

  // identification value, bit zero fixed to one
  localparam logic [`BSREG_ID_W-1:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MFR, `BSREG_ID_LSB_BIT};

  // =====================================================================
  // pin synchronisers
  logic [3:0] sync1_r;          // first stage, read only by second stage
  logic [3:0] sync2_r;          // second stage
  logic tck_d_r;                // delayed scan clock for edge finding
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_n_s;
  logic tck_rise;
  logic tck_fall;

  // two flip-flops on every scan pin, reset state idle and scan reset active
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      tck_d_r <= 1'h0;
    end else begin
      sync1_r <= SCAN_PINS_I;
      sync2_r <= sync1_r;
      tck_d_r <= sync2_r[3];
    end
  end

  assign tck_s = sync2_r[3];
  assign tms_s = sync2_r[2];
  assign tdi_s = sync2_r[1];
  assign trst_n_s = sync2_r[0];
  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;

  // =====================================================================
  // tap controller
  bsreg_pkg::bsreg_tap_e state_r;     // current state
  bsreg_pkg::bsreg_tap_e state_nxt;

  // next state on each scan clock rising edge
  always_comb begin
    state_nxt = state_r;
    if (!trst_n_s) begin
      state_nxt = bsreg_pkg::TLR;
    end else if (tck_rise) begin
      case (state_r)
        bsreg_pkg::TLR: state_nxt = tms_s ? bsreg_pkg::TLR : bsreg_pkg::RTI;
        bsreg_pkg::RTI: state_nxt = tms_s ? bsreg_pkg::SEL_DR : bsreg_pkg::RTI;
        bsreg_pkg::SEL_DR: state_nxt = tms_s ? bsreg_pkg::SEL_IR : bsreg_pkg::CAP_DR;
        bsreg_pkg::CAP_DR: state_nxt = tms_s ? bsreg_pkg::EX1_DR : bsreg_pkg::SH_DR;
        bsreg_pkg::SH_DR: state_nxt = tms_s ? bsreg_pkg::EX1_DR : bsreg_pkg::SH_DR;
        bsreg_pkg::EX1_DR: state_nxt = tms_s ? bsreg_pkg::UPD_DR : bsreg_pkg::PA_DR;
        bsreg_pkg::PA_DR: state_nxt = tms_s ? bsreg_pkg::EX2_DR : bsreg_pkg::PA_DR;
        bsreg_pkg::EX2_DR: state_nxt = tms_s ? bsreg_pkg::UPD_DR : bsreg_pkg::SH_DR;
        bsreg_pkg::UPD_DR: state_nxt = tms_s ? bsreg_pkg::SEL_DR : bsreg_pkg::RTI;
        bsreg_pkg::SEL_IR: state_nxt = tms_s ? bsreg_pkg::TLR : bsreg_pkg::CAP_IR;
        bsreg_pkg::CAP_IR: state_nxt = tms_s ? bsreg_pkg::EX1_IR : bsreg_pkg::SH_IR;
        bsreg_pkg::SH_IR: state_nxt = tms_s ? bsreg_pkg::EX1_IR : bsreg_pkg::SH_IR;
        bsreg_pkg::EX1_IR: state_nxt = tms_s ? bsreg_pkg::UPD_IR : bsreg_pkg::PA_IR;
        bsreg_pkg::PA_IR: state_nxt = tms_s ? bsreg_pkg::EX2_IR : bsreg_pkg::PA_IR;
        bsreg_pkg::EX2_IR: state_nxt = tms_s ? bsreg_pkg::UPD_IR : bsreg_pkg::SH_IR;
        bsreg_pkg::UPD_IR: state_nxt = tms_s ? bsreg_pkg::SEL_DR : bsreg_pkg::RTI;
        default: state_nxt = bsreg_pkg::TLR;
      endcase
    end
  end

  // power-up lands in the reset state
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_r <= bsreg_pkg::TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // =====================================================================
  // instruction register and decode
  logic [`BSREG_IR_W-1:0] ir_shift;   // instruction shift stage
  logic [`BSREG_IR_W-1:0] ir_par;     // current instruction
  logic in_tlr;
  logic sel_id;
  logic sel_bsr;
  logic sel_byp;

  assign in_tlr = (state_r == bsreg_pkg::TLR);

  // three-bit instruction, latched on falling edge in update
  // reset state forces the identification instruction
  bsreg_stage #(
    .W(`BSREG_IR_W),
    .PAR_RST(`BSREG_INS_IDCODE)
  ) u_ir (
    .clk_i(CLK_SYS_I),
    .arst_n_i(ARST_N_I),
    .capture_i(tck_rise && state_r == bsreg_pkg::CAP_IR),
    .shift_i(tck_rise && state_r == bsreg_pkg::SH_IR),
    .update_i(tck_fall && state_r == bsreg_pkg::UPD_IR),
    .force_i(in_tlr),
    .serial_i(tdi_s),
    .capture_val_i(`BSREG_IR_CAPTURE),
    .shift_o(ir_shift),
    .par_o(ir_par)
  );

  // register selection from the current instruction
  always_comb begin
    sel_id = 1'h0;
    sel_bsr = 1'h0;
    sel_byp = 1'h0;
    case (ir_par)
      `BSREG_INS_IDCODE: sel_id = 1'h1;
      `BSREG_INS_EXTEST, `BSREG_INS_SAMPLE: sel_bsr = 1'h1;
      default: sel_byp = 1'h1;   // bypass, clamp, highz and unused codes
    endcase
  end

  // =====================================================================
  // identification register
  logic [`BSREG_ID_W-1:0] id_shift;   // identification shift stage

  // capture on rising edge in capture, shift out in shift
  bsreg_stage #(
    .W(`BSREG_ID_W),
    .PAR_RST(ID_VALUE)
  ) u_id (
    .clk_i(CLK_SYS_I),
    .arst_n_i(ARST_N_I),
    .capture_i(tck_rise && state_r == bsreg_pkg::CAP_DR && sel_id),
    .shift_i(tck_rise && state_r == bsreg_pkg::SH_DR && sel_id),
    .update_i(tck_fall && state_r == bsreg_pkg::UPD_DR && sel_id),
    .force_i(1'h0),
    .serial_i(tdi_s),
    .capture_val_i(ID_VALUE),
    .shift_o(id_shift),
    .par_o()
  );

  // =====================================================================
  // boundary scan register, cell 0 nearest the serial output
  logic [BSR_LEN-1:0] bsr_shift;   // boundary shift stage
  logic [BSR_LEN-1:0] bsr_par;     // boundary parallel stage

  bsreg_stage #(
    .W(BSR_LEN),
    .PAR_RST('0)
  ) u_bsr (
    .clk_i(CLK_SYS_I),
    .arst_n_i(ARST_N_I),
    .capture_i(tck_rise && state_r == bsreg_pkg::CAP_DR && sel_bsr),
    .shift_i(tck_rise && state_r == bsreg_pkg::SH_DR && sel_bsr),
    .update_i(tck_fall && state_r == bsreg_pkg::UPD_DR && sel_bsr),
    .force_i(1'h0),
    .serial_i(tdi_s),
    .capture_val_i(BSR_PIN_I),
    .shift_o(bsr_shift),
    .par_o(bsr_par)
  );

  // =====================================================================
  // bypass bit and serial output
  logic byp_r;      // one-bit bypass
  logic byp_nxt;
  logic tdo_r;      // serial output, changes on falling edge
  logic tdo_nxt;
  logic oe_r;       // serial output enable
  logic oe_nxt;

  // bypass captures zero, shifts serial input
  // output takes the selected register's bit zero on falling edge
  always_comb begin
    byp_nxt = byp_r;
    tdo_nxt = tdo_r;
    oe_nxt = oe_r;
    if (tck_rise && sel_byp && state_r == bsreg_pkg::CAP_DR) begin
      byp_nxt = 1'h0;
    end else if (tck_rise && sel_byp && state_r == bsreg_pkg::SH_DR) begin
      byp_nxt = tdi_s;
    end
    if (tck_fall) begin
      oe_nxt = (state_r == bsreg_pkg::SH_DR) || (state_r == bsreg_pkg::SH_IR);
      if (state_r == bsreg_pkg::SH_IR) begin
        tdo_nxt = ir_shift[0];
      end else if (sel_id) begin
        tdo_nxt = id_shift[0];
      end else if (sel_bsr) begin
        tdo_nxt = bsr_shift[0];
      end else begin
        tdo_nxt = byp_r;
      end
    end
  end

  // registers for bypass and serial output
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      byp_r <= 1'h0;
      tdo_r <= 1'h0;
      oe_r <= 1'h0;
    end else begin
      byp_r <= byp_nxt;
      tdo_r <= tdo_nxt;
      oe_r <= oe_nxt;
    end
  end

  // =====================================================================
  // outputs
  assign SCAN_SERIAL_OUT_O = tdo_r;
  assign SCAN_SERIAL_OUT_OE_O = oe_r;
  assign BSR_PAR_O = bsr_par;
  assign IR_O = ir_par;
  assign PIN_CTL_O.bsr_drive = (ir_par == `BSREG_INS_EXTEST) || (ir_par == `BSREG_INS_CLAMP);
  assign PIN_CTL_O.highz = (ir_par == `BSREG_INS_HIGHZ);
  assign PIN_CTL_O.tx_sync_dir_cell = bsr_par[`BSREG_CELL_TX_SYNC_DIR];
  assign PIN_CTL_O.bus_dir_cell = bsr_par[`BSREG_CELL_BUS_DIR];

  // =====================================================================
  // assertions, on the default clock and reset declared at the top
  property p_id_capture;
    (tck_rise && state_r == bsreg_pkg::CAP_DR && sel_id) |=> (id_shift == ID_VALUE);
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("id code not captured");
  property p_id_lsb;
    (tck_rise && state_r == bsreg_pkg::CAP_DR && sel_id) |=> id_shift[0] ##1 (!tck_fall || tdo_nxt || !sel_id);
  endproperty
  a_id_lsb: assert property (p_id_lsb) else $error("id lsb not one");
  property p_id_fields;
    (tck_rise && state_r == bsreg_pkg::CAP_DR && sel_id) |=>
      (id_shift[31:28] == ID_VERSION && id_shift[27:12] == ID_PART && id_shift[11:1] == ID_MFR);
  endproperty
  a_id_fields: assert property (p_id_fields) else $error("id fields misplaced");
  property p_id_out;
    (tck_fall && state_r == bsreg_pkg::SH_DR && sel_id) |=> (tdo_r == $past(id_shift[0]) && oe_r);
  endproperty
  a_id_out: assert property (p_id_out) else $error("id bit not on serial out");
  property p_tlr_idcode;
    in_tlr |=> (ir_par == `BSREG_INS_IDCODE && sel_id);
  endproperty
  a_tlr_idcode: assert property (p_tlr_idcode) else $error("reset state lost id selection");
  property p_scan_reset;
    !trst_n_s |=> in_tlr ##1 (ir_par == `BSREG_INS_IDCODE);
  endproperty
  a_scan_reset: assert property (p_scan_reset) else $error("scan reset not honoured");
  property p_byp_shift;
    (tck_rise && state_r == bsreg_pkg::SH_DR && sel_byp) |=> (byp_r == $past(tdi_s));
  endproperty
  a_byp_shift: assert property (p_byp_shift) else $error("bypass did not shift");
  property p_bsr_shift;
    (tck_rise && state_r == bsreg_pkg::SH_DR && sel_bsr) |=>
      (bsr_shift[BSR_LEN-1] == $past(tdi_s) && bsr_shift[BSR_LEN-2:0] == $past(bsr_shift[BSR_LEN-1:1]));
  endproperty
  a_bsr_shift: assert property (p_bsr_shift) else $error("boundary shift wrong");
  property p_bsr_hold;
    (state_r == bsreg_pkg::SH_DR) |=> $stable(bsr_par);
  endproperty
  a_bsr_hold: assert property (p_bsr_hold) else $error("parallel stage moved while shifting");
  property p_tx_frame_sync_pin_dir;
    (tck_fall && state_r == bsreg_pkg::UPD_DR && sel_bsr) |=>
      (PIN_CTL_O.tx_sync_dir_cell == $past(bsr_shift[`BSREG_CELL_TX_SYNC_DIR]));
  endproperty
  a_tx_frame_sync_pin_dir: assert property (p_tx_frame_sync_pin_dir) else $error("frame sync direction not updated");
  property p_bus_dir;
    (tck_fall && state_r == bsreg_pkg::UPD_DR && sel_bsr) |=>
      (PIN_CTL_O.bus_dir_cell == $past(bsr_shift[`BSREG_CELL_BUS_DIR]));
  endproperty
  a_bus_dir: assert property (p_bus_dir) else $error("bus direction not updated");
  property p_ir_update;
    (tck_fall && state_r == bsreg_pkg::UPD_IR) |=> (ir_par == $past(ir_shift));
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("instruction not latched");

  // covers for the main scenarios
  property p_cov_id_shift;
    (tck_rise && state_r == bsreg_pkg::SH_DR && sel_id);
  endproperty
  c_id_shift: cover property (p_cov_id_shift);
  property p_cov_extest;
    (tck_fall && state_r == bsreg_pkg::UPD_DR && PIN_CTL_O.bsr_drive);
  endproperty
  c_extest: cover property (p_cov_extest);
  property p_cov_bypass;
    (tck_rise && state_r == bsreg_pkg::SH_DR && sel_byp);
  endproperty
  c_bypass: cover property (p_cov_bypass);

endmodule

// ---- design/bsreg_consts.svh ----
// constants for the boundary scan test data registers
`ifndef BSREG_CONSTS_SVH
`define BSREG_CONSTS_SVH

// =====================================================================
// register lengths
`define BSREG_IR_W 3
`define BSREG_ID_W 32
`define BSREG_BSR_LEN 73

// =====================================================================
// instruction codes
`define BSREG_INS_EXTEST 3'h0
`define BSREG_INS_IDCODE 3'h1
`define BSREG_INS_SAMPLE 3'h2
`define BSREG_INS_CLAMP 3'h3
`define BSREG_INS_HIGHZ 3'h4
`define BSREG_INS_BYPASS 3'h7

// =====================================================================
// fixed capture value of the instruction shift stage
`define BSREG_IR_CAPTURE 3'h1

// =====================================================================
// identification field positions
`define BSREG_ID_LSB_BIT 1'h1
`define BSREG_ID_MFR_LSB 1
`define BSREG_ID_MFR_W 11
`define BSREG_ID_PART_LSB 12
`define BSREG_ID_PART_W 16
`define BSREG_ID_VER_LSB 28
`define BSREG_ID_VER_W 4

// =====================================================================
// boundary cell positions
`define BSREG_CELL_TX_SYNC_DIR 61
`define BSREG_CELL_TX_SYNC_DATA 60
`define BSREG_CELL_BUS_DIR 43

`endif

// ---- design/bsreg_pkg.sv ----
// types shared by the boundary scan test data registers
`include "bsreg_consts.svh"

package bsreg_pkg;

  // =====================================================================
  // test access port controller states
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } bsreg_tap_e;

  // =====================================================================
  // scan pins coming from the external test controller
  typedef struct packed {
    logic scan_clock_in;     // scan clock, sampled by the system clock
    logic scan_mode_select;  // mode select
    logic scan_serial_in;    // serial data in
    logic scan_reset_n;      // scan reset, active low
  } bsreg_pins_s;

  // =====================================================================
  // pin control derived from instruction and boundary cells
  typedef struct packed {
    logic bsr_drive;         // pins driven from boundary parallel stage
    logic highz;             // all digital outputs high impedance
    logic tx_sync_dir_cell;  // 1 = frame sync pin is an output
    logic bus_dir_cell;      // 1 = eight bus pins are outputs
  } bsreg_pinctl_s;

endpackage

// ---- design/bsreg_stage.sv ----
// shift stage with latched parallel output stage
`timescale 1ns/1ns

module bsreg_stage #(
  parameter int W = 3,
  parameter logic [W-1:0] PAR_RST = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // controls: capture, shift and update one system clock wide, force held as a level
  input wire logic capture_i,
  input wire logic shift_i,
  input wire logic update_i,
  input wire logic force_i,
  // data
  input wire logic serial_i,
  input wire logic [W-1:0] capture_val_i,
  output logic [W-1:0] shift_o,
  output logic [W-1:0] par_o
);

  logic [W-1:0] shift_r;    // shift path
  logic [W-1:0] shift_nxt;
  logic [W-1:0] par_r;      // latched parallel output
  logic [W-1:0] par_nxt;

  // =====================================================================
  // next values: capture beats shift, force beats update
  always_comb begin
    shift_nxt = shift_r;
    par_nxt = par_r;
    if (capture_i) begin
      shift_nxt = capture_val_i;
    end else if (shift_i) begin
      // bit 0 sits next to the serial output
      shift_nxt = {serial_i, shift_r[W-1:1]};
    end
    if (force_i) begin
      par_nxt = PAR_RST;
    end else if (update_i) begin
      // parallel stage changes only on update or force, never while shifting
      par_nxt = shift_r;
    end
  end

  // =====================================================================
  // registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_r <= '0;
      par_r <= PAR_RST;
    end else begin
      shift_r <= shift_nxt;
      par_r <= par_nxt;
    end
  end

  assign shift_o = shift_r;
  assign par_o = par_r;

endmodule

// ---- test/bsreg_ctl_model.sv ----
// behavioural model of the external boundary-scan test controller
`timescale 1ns/1ns

module bsreg_ctl_model (
  // scan pins driven toward the device
  output bsreg_pkg::bsreg_pins_s pins_o,
  // serial data back from the device
  input wire logic tdo_i
);
  // =====================================================================
  // idle levels: scan clock stands low, scan reset released
  initial begin
    pins_o = 4'h1;
  end

  // =====================================================================
  // one scan clock period of 125 ns, low half first
  task automatic tck(input logic tms, input logic tdi, output logic tdo);
    pins_o.scan_mode_select = tms;
    pins_o.scan_serial_in = tdi;
    #62;
    // take the bit shown since the last fall, just before the rise
    tdo = tdo_i;
    pins_o.scan_clock_in = 1'b1;
    #40;
    // the rise has passed the synchroniser by now: serial in no longer qualified, show the inverse
    pins_o.scan_serial_in = ~tdi;
    #23;
    pins_o.scan_clock_in = 1'b0;
  endtask

  // =====================================================================
  // shift n bits lsb first, then exit, update and return to idle
  task automatic shift(input int n, input logic [72:0] din, output logic [72:0] dout);
    logic b;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      // last bit leaves the shift state
      tck(i == n - 1, din[i], b);
      dout[i] = b;
    end
    // exit1 to update, whose fall latches the parallel stage
    tck(1'b1, 1'b0, b);
    tck(1'b0, 1'b0, b);
  endtask

  // data register scan starting from run-test-idle
  task automatic dr_scan(input int n, input logic [72:0] din, output logic [72:0] dout);
    logic b;
    tck(1'b1, 1'b0, b);
    tck(1'b0, 1'b0, b);
    tck(1'b0, 1'b0, b);
    shift(n, din, dout);
  endtask

  // instruction register scan starting from run-test-idle
  task automatic ir_scan(input int n, input logic [72:0] din, output logic [72:0] dout);
    logic b;
    tck(1'b1, 1'b0, b);
    tck(1'b1, 1'b0, b);
    tck(1'b0, 1'b0, b);
    tck(1'b0, 1'b0, b);
    shift(n, din, dout);
  endtask

  // pulse the scan reset pin long enough to pass the synchroniser
  task automatic scan_reset();
    pins_o.scan_reset_n = 1'b0;
    #100;
    pins_o.scan_reset_n = 1'b1;
    #100;
  endtask
endmodule

// ---- test/tb.sv ----
// self-checking bench for the boundary scan test data registers
`timescale 1ns/1ns
`include "bsreg_consts.svh"

module tb;
  // =====================================================================
  // identification values, arbitrary, chosen for this bench only
  localparam logic [3:0] ID_VER = 4'h6;
  localparam logic [15:0] ID_PRT = 16'h3C5A;
  localparam logic [10:0] ID_MAN = 11'h1D2;

  logic clk_sys = 1'b0; // system clock
  logic arst_n = 1'b0; // async reset, active low
  bsreg_pkg::bsreg_pins_s pins; // scan pins from the model
  bsreg_pkg::bsreg_pinctl_s pin_ctl; // decoded pin control
  logic tdo; // serial out
  logic tdo_oe; // serial out enable
  logic [72:0] bsr_pin = 73'h0; // boundary capture values
  logic [72:0] bsr_par; // boundary parallel stage
  logic [2:0] ir; // current instruction
  int bad_count = 0; // mismatches seen
  int comparisons = 0; // compares made
  logic [31:0] rng = 32'h00000063; // xorshift state

  always #4 clk_sys = ~clk_sys;

  // =====================================================================
  // design and far-side model
  bsreg_top #(.BSR_LEN(`BSREG_BSR_LEN), .ID_VERSION(ID_VER), .ID_PART(ID_PRT), .ID_MFR(ID_MAN)) dut (
    .CLK_SYS_I(clk_sys), .ARST_N_I(arst_n), .SCAN_PINS_I(pins), .SCAN_SERIAL_OUT_O(tdo),
    .SCAN_SERIAL_OUT_OE_O(tdo_oe), .BSR_PIN_I(bsr_pin), .BSR_PAR_O(bsr_par), .PIN_CTL_O(pin_ctl), .IR_O(ir));
  bsreg_ctl_model ctl (.pins_o(pins), .tdo_i(tdo));

  // =====================================================================
  // helpers: random source, expectations, compare, verdict
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic logic [72:0] rand73();
    return 73'({rnd(), rnd(), rnd()});
  endfunction

  // expected code: version, part, maker, fixed one
  function automatic logic [31:0] exp_id();
    return {ID_VER, ID_PRT, ID_MAN, 1'b1};
  endfunction

  task automatic check(input logic [72:0] seen, input logic [72:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // =====================================================================
  // watchdog: the run needs well under a third of this span
  initial begin
    #500000;
    bad_count++;
    test_done();
  end

  // =====================================================================
  // main sequence
  initial begin
    logic [72:0] din;
    logic [72:0] dout;
    logic [72:0] exp;
    logic [31:0] id;
    logic b;
    repeat (8) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    // reset state: identification current, outputs quiet
    check(73'(ir), 73'(`BSREG_INS_IDCODE));
    check(bsr_par, 73'h0);
    check(73'(tdo_oe), 73'h0);
    repeat (6) @(posedge clk_sys);
    ctl.tck(1'b0, 1'b0, b);
    // read identification straight after reset, 64 bits to show length
    din = rand73();
    ctl.dr_scan(64, din, dout);
    check(73'(dout[31:0]), 73'(exp_id()));
    check(73'(dout[63:32]), 73'(din[31:0]));
    // every instruction code, then the register it selects
    for (int c = 0; c < 8; c++) begin
      ctl.ir_scan(3, 73'(c), dout);
      check(73'(dout[2:0]), 73'(`BSREG_IR_CAPTURE));
      check(73'(ir), 73'(c));
      check(73'(pin_ctl.bsr_drive), 73'(c == 0 || c == 3));
      check(73'(pin_ctl.highz), 73'(c == 4));
      din = rand73();
      if (c == 1) begin
        // identification path
        ctl.dr_scan(32, din, dout);
        check(73'(dout[31:0]), 73'(exp_id()));
      end else if (c == 0 || c == 2) begin
        // boundary path with both direction cells at opposite corners
        @(posedge clk_sys);
        #1 bsr_pin = rand73();
        din[61] = (c == 0);
        din[43] = (c != 0);
        ctl.dr_scan(73, din, dout);
        check(dout, bsr_pin);
        check(bsr_par, din);
        check(73'(pin_ctl.tx_sync_dir_cell), 73'(din[61]));
        check(73'(pin_ctl.bus_dir_cell), 73'(din[43]));
      end else begin
        // one-bit path: captured zero first, then input delayed one bit
        exp = bsr_par;
        ctl.dr_scan(8, din, dout);
        check(73'(dout[7:0]), 73'({din[6:0], 1'b0}));
        check(bsr_par, exp);
      end
    end
    // five rises with mode select high reach the reset state
    repeat (5) ctl.tck(1'b1, 1'b0, b);
    check(73'(ir), 73'(`BSREG_INS_IDCODE));
    ctl.tck(1'b0, 1'b0, b);
    // scan reset pin also restores identification selection
    ctl.ir_scan(3, 73'(`BSREG_INS_BYPASS), dout);
    ctl.scan_reset();
    check(73'(ir), 73'(`BSREG_INS_IDCODE));
    ctl.tck(1'b0, 1'b0, b);
    ctl.dr_scan(32, din, dout);
    check(73'(dout[31:0]), 73'(exp_id()));
    // pause in mid-shift holds the register; shifting resumes where it stopped
    id = exp_id();
    ctl.tck(1'b1, 1'b0, b);
    ctl.tck(1'b0, 1'b0, b);
    ctl.tck(1'b0, 1'b0, b);
    ctl.tck(1'b0, 1'b0, b);
    check(73'(b), 73'(id[0]));
    ctl.tck(1'b1, 1'b0, b);
    check(73'(b), 73'(id[1]));
    ctl.tck(1'b0, 1'b0, b);
    ctl.tck(1'b0, 1'b0, b);
    ctl.tck(1'b1, 1'b0, b);
    ctl.tck(1'b0, 1'b0, b);
    // back in shift: output enabled and showing the next unshifted bit
    repeat (6) @(posedge clk_sys);
    #1;
    check(73'(tdo_oe), 73'h1);
    check(73'(tdo), 73'(id[2]));
    ctl.tck(1'b1, 1'b0, b);
    check(73'(b), 73'(id[2]));
    ctl.tck(1'b1, 1'b0, b);
    ctl.tck(1'b0, 1'b0, b);
    check(73'(tdo_oe), 73'h0);
    test_done();
  end
endmodule
